// >>> core/bridge_cfg_header_regs.sv
// Primary-side header registers of the virtual bridge function.
`timescale 1ns/1ps
module bridge_cfg_header_regs
	import bridge_cfg_pkg::*;
#(
	// Stepping code returned by the revision register; value is arbitrary.
	parameter logic [7:0] REVISION_CODE = 8'h5a,
	// Width of the dword index on the configuration port.
	parameter int DW_INDEX_W = 6
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Configuration access request.
	input wire logic cfg_valid_in,
	input wire cfg_req_t cfg_req_in,
	// Configuration access answer.
	output cfg_rsp_t cfg_rsp_out,
	// Event from the hub interface: an SERR message was sent.
	input wire logic serr_msg_sent_in,
	// Current state of the signaled system error flag.
	output logic system_error_signaled_out
);

	// The index field of the carrier is fixed; refuse a mismatched width.
	initial begin
		if (DW_INDEX_W != $bits(cfg_req_in.dw_index)) begin
			$error("DW_INDEX_W must match the request carrier");
		end
	end

	// Dword indices of the three dwords this block answers.
	localparam logic [5:0] DW_STATUS = OFS_STATUS[7:2];
	localparam logic [5:0] DW_CLASS = OFS_REVISION[7:2];
	localparam logic [5:0] DW_LATENCY = OFS_LATENCY[7:2];

	// Byte lanes of the status high byte and the latency register inside their dwords.
	localparam logic [1:0] LANE_STATUS_HI = OFS_STATUS[1:0] + 2'd1;
	localparam logic [1:0] LANE_LATENCY = OFS_LATENCY[1:0];

	// Signaled system error flag, the only stored status bit.
	logic system_error_signaled;

	// Stored latency bits; bits 2:0 are never written.
	logic [7:0] latency_q;
	logic [7:0] latency_d;

	// Answer registers.
	cfg_rsp_t rsp_q;
	cfg_rsp_t rsp_d;

	// Decoded strobes for this cycle's access.
	logic wr_status_hi;
	logic wr_latency;
	logic sse_clear;

	// Builds the full status word from the one stored bit.
	// Every other bit is a constant, so no write can reach them.
	function automatic logic [15:0] build_status(input logic sse);
		logic [15:0] sts;
		sts = STS_HARDWIRED;
		sts[STS_SSE_BIT] = sse;
		return sts;
	endfunction

	// Tells whether a request hits a dword and has a given lane enabled.
	function automatic logic lane_write(input cfg_req_t req,
		input logic [5:0] dw, input logic [1:0] lane);
		return req.wr && (req.dw_index == dw) && req.byte_en[lane];
	endfunction

	// Write strobes for the two writable places.
	always_comb begin
		wr_status_hi = cfg_valid_in &&
			lane_write(cfg_req_in, DW_STATUS, LANE_STATUS_HI);
		wr_latency = cfg_valid_in &&
			lane_write(cfg_req_in, DW_LATENCY, LANE_LATENCY);
	end

	// A one in bit 14 of the status clears the flag; a zero does nothing.
	// Bit 14 of the status sits at bit 30 of its dword.
	assign sse_clear = wr_status_hi &&
		cfg_req_in.wdata[16 + STS_SSE_BIT];

	// Sticky flag; a new SERR message beats a clear in the same cycle.
	sticky_w1c_flag u_sse_flag (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.set_in(serr_msg_sent_in),
		.clr_in(sse_clear),
		.flag_out(system_error_signaled)
	);

	assign system_error_signaled_out = system_error_signaled;

	// Latency storage: only bits 7:3 take the written value.
	// The value steers nothing; it only satisfies bridge set-up software.
	always_comb begin
		latency_d = latency_q;
		if (wr_latency) begin
			latency_d = cfg_req_in.wdata[8*LANE_LATENCY +: 8] &
				LATENCY_WR_MASK;
		end
	end

	// Latency register, reset to zero.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			latency_q <= LATENCY_RESET;
		end else begin
			latency_q <= latency_d;
		end
	end

	// Read multiplexer and answer build.
	// Writes also receive an answer so the requester can pace itself.
	// Reads of dwords outside this block return zero.
	always_comb begin
		rsp_d.ack = cfg_valid_in;
		rsp_d.rdata = rsp_q.rdata;
		if (cfg_valid_in && !cfg_req_in.wr) begin
			case (cfg_req_in.dw_index)
				DW_STATUS: begin
					// Low half belongs to the command register elsewhere.
					rsp_d.rdata = {build_status(system_error_signaled),
						16'h0000};
				end
				DW_CLASS: begin
					// Programming interface byte at 09h reads zero.
					rsp_d.rdata = {BASE_CLASS_VAL, SUB_CLASS_VAL,
						8'h00, REVISION_CODE};
				end
				DW_LATENCY: begin
					// Header type is a constant with no storage behind it.
					rsp_d.rdata = {8'h00, HEADER_VAL, latency_q,
						8'h00};
				end
				default: begin
					rsp_d.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// Answer register: ack pulses one cycle after the request.
	// Read data holds until the next read answer replaces it.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	assign cfg_rsp_out = rsp_q;

	default clocking main_cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	// Helper: true when this request reads a given dword.
	logic rd_status;
	logic rd_class;
	logic rd_latency;
	assign rd_status = cfg_valid_in && !cfg_req_in.wr &&
		cfg_req_in.dw_index == DW_STATUS;
	assign rd_class = cfg_valid_in && !cfg_req_in.wr &&
		cfg_req_in.dw_index == DW_CLASS;
	assign rd_latency = cfg_valid_in && !cfg_req_in.wr &&
		cfg_req_in.dw_index == DW_LATENCY;

	// An SERR message shows up in the status read two cycles on.
	sse_read_back_a: assert property (
		serr_msg_sent_in ##1 rd_status |=>
		cfg_rsp_out.rdata[16 + STS_SSE_BIT])
		else $error("signaled system error not reported");

	// Writing one clears the flag when no new event arrives.
	sse_clear_a: assert property (
		sse_clear && !serr_msg_sent_in |=>
		!system_error_signaled_out)
		else $error("write one did not clear flag");

	// Writing zero to bit 14 leaves a set flag alone.
	sse_zero_write_a: assert property (
		system_error_signaled_out && !sse_clear |=>
		system_error_signaled_out)
		else $error("flag lost without write one");

	// Every fixed status bit reads as its constant.
	// The sticky bit is masked out; the rest must equal the constant.
	sts_fixed_bits_a: assert property (rd_status |=>
		((cfg_rsp_out.rdata[31:16] & 16'hbfff) ==
		16'h0020))
		else $error("hardwired status bit wrong");

	// Parity and abort bits 15, 13, 12, 11 and 8 read zero.
	parity_bits_zero_a: assert property (rd_status |=>
		(cfg_rsp_out.rdata[31] == 1'b0) &&
		(cfg_rsp_out.rdata[29:27] == 3'h0) &&
		(cfg_rsp_out.rdata[24] == 1'b0))
		else $error("parity or abort status bit set");

	// Select timing field at bits 10:9 reads zero.
	sel_timing_zero_a: assert property (rd_status |=>
		cfg_rsp_out.rdata[26:25] == 2'h0)
		else $error("select timing field not zero");

	// Fast back-to-back bit 7 reads zero.
	fast_b2b_zero_a: assert property (rd_status |=>
		cfg_rsp_out.rdata[23] == 1'b0)
		else $error("fast back-to-back bit set");

	// Reserved status bits 6 and 4:0 read zero.
	reserved_sts_zero_a: assert property (rd_status |=>
		(cfg_rsp_out.rdata[22] == 1'b0) &&
		(cfg_rsp_out.rdata[20:16] == 5'h00))
		else $error("reserved status bit set");

	// The low half of the status dword is not ours and reads zero.
	status_low_zero_a: assert property (rd_status |=>
		cfg_rsp_out.rdata[15:0] == 16'h0000)
		else $error("status dword low half not zero");

	// With the flag clear the status reads its reset value.
	status_reset_a: assert property (
		rd_status && !system_error_signaled_out |=>
		cfg_rsp_out.rdata[31:16] == STS_RESET)
		else $error("status not at reset value");

	// Capability bit 5 always reads one.
	sts_cap66_a: assert property (rd_status |=>
		cfg_rsp_out.rdata[16 + STS_CAP66_BIT])
		else $error("66 MHz capability bit not set");

	// Class dword returns revision, sub-class and base class.
	class_dword_a: assert property (rd_class |=>
		cfg_rsp_out.rdata == {BASE_CLASS_VAL, SUB_CLASS_VAL, 8'h00,
		REVISION_CODE})
		else $error("class dword wrong");

	// Sub-class byte is fixed.
	sub_class_a: assert property (rd_class |=>
		cfg_rsp_out.rdata[23:16] == SUB_CLASS_VAL)
		else $error("sub-class byte wrong");

	// Base class byte is fixed.
	base_class_a: assert property (rd_class |=>
		cfg_rsp_out.rdata[31:24] == BASE_CLASS_VAL)
		else $error("base class byte wrong");

	// Revision byte is fixed, whatever was written before.
	revision_fixed_a: assert property (rd_class |=>
		cfg_rsp_out.rdata[7:0] == REVISION_CODE)
		else $error("revision byte wrong");

	// Read data only moves on a read answer, so writes never show up.
	rdata_hold_a: assert property (
		!(cfg_valid_in && !cfg_req_in.wr) |=>
		$stable(cfg_rsp_out.rdata))
		else $error("read data moved without a read");

	// A latency write is read back with the low three bits cleared.
	latency_store_a: assert property (
		wr_latency ##1 rd_latency |=>
		cfg_rsp_out.rdata[15:8] ==
		($past(cfg_req_in.wdata[15:8], 2) & LATENCY_WR_MASK))
		else $error("latency value not stored");

	// Header byte never changes, whatever was written.
	header_fixed_a: assert property (rd_latency |=>
		cfg_rsp_out.rdata[23:16] == HEADER_VAL)
		else $error("header type wrong");

	// Bytes around latency and header in that dword read zero.
	latency_dword_zero_a: assert property (rd_latency |=>
		(cfg_rsp_out.rdata[31:24] == 8'h00) &&
		(cfg_rsp_out.rdata[7:0] == 8'h00))
		else $error("unused latency dword byte set");

	// The latency byte only changes on a write to its lane.
	latency_hold_a: assert property (!wr_latency |=>
		$stable(latency_q))
		else $error("latency changed without write");

	// Reserved latency bits never hold ones.
	latency_low_a: assert property (latency_q[2:0] == 3'b000)
		else $error("reserved latency bits set");

	// Each request gets exactly one ack one cycle later.
	ack_timing_a: assert property (
		cfg_valid_in |=> cfg_rsp_out.ack)
		else $error("request not acknowledged");

	// No request, no ack: each ack belongs to exactly one request.
	ack_single_a: assert property (
		!cfg_valid_in |=> !cfg_rsp_out.ack)
		else $error("ack without request");

	// Scenario: flag set, then cleared by software.
	sse_set_clear_c: cover property (
		serr_msg_sent_in ##[1:4] sse_clear ##1 !system_error_signaled_out);

	// Scenario: event and clear collide in the same cycle.
	sse_collide_c: cover property (serr_msg_sent_in && sse_clear);

	// Scenario: latency written and read back.
	latency_rw_c: cover property (wr_latency ##[1:4] rd_latency);

	// Scenario: class dword read after a write to it.
	class_after_write_c: cover property (
		cfg_valid_in && cfg_req_in.wr &&
		cfg_req_in.dw_index == DW_CLASS ##1 rd_class);

	// Scenario: status read with the flag set.
	status_flag_read_c: cover property (
		rd_status && system_error_signaled_out);

endmodule

// >>> include/bridge_cfg_pkg.sv
// Constants and carrier types for the bridge primary-side header registers.
// Operation
// - Hub SERR message sets status bit 14.
// - Bit 14 holds until software writes one.
// - Parity and abort status bits read zero.
// - Select timing field reads fixed 00b.
// - Fast back-to-back bit reads zero.
// - 66 MHz capable bit reads one.
// - Status register at 06h resets 0020h.
// - Revision at 08h fixed, writes ignored.
// - Sub-class at 0Ah always reads 04h.
// - Base class at 0Bh always reads 06h.
// - Latency bits 7:3 are plain read/write storage.
// - Latency resets 00h; bits 2:0 reserved.
// - Header type at 0Eh reads 01h, no storage.
package bridge_cfg_pkg;

	// Byte offsets of the registers in configuration space.
	localparam logic [7:0] OFS_STATUS = 8'h06;
	localparam logic [7:0] OFS_REVISION = 8'h08;
	localparam logic [7:0] OFS_SUB_CLASS = 8'h0a;
	localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
	localparam logic [7:0] OFS_LATENCY = 8'h0d;
	localparam logic [7:0] OFS_HEADER = 8'h0e;

	// Field positions inside the status register.
	localparam int STS_SSE_BIT = 14;
	localparam int STS_CAP66_BIT = 5;

	// Values after reset and hardwired values.
	localparam logic [15:0] STS_RESET = 16'h0020;
	localparam logic [15:0] STS_HARDWIRED = 16'h0020;
	localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
	localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
	localparam logic [7:0] HEADER_VAL = 8'h01;
	localparam logic [7:0] LATENCY_RESET = 8'h00;
	localparam logic [7:0] LATENCY_WR_MASK = 8'hf8;

	// Read data stands this many cycles after the request edge.
	localparam int ANSWER_CYCLES = 1;

	// One configuration access: dword index, byte enables, data.
	typedef struct packed {
		logic wr;
		logic [5:0] dw_index;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_req_t;

	// Registered answer to one configuration access.
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

endpackage

// >>> core/sticky_w1c_flag.sv
// Sticky status flag that hardware sets and software clears with a one.
`timescale 1ns/1ps
module sticky_w1c_flag (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Set event and clear strobe.
	input wire logic set_in,
	input wire logic clr_in,
	// Current flag value.
	output logic flag_out
);

	// Flag storage.
	logic flag_q;
	logic flag_d;

	// Set wins over clear so that an event in the clearing cycle survives.
	always_comb begin
		flag_d = flag_q;
		if (set_in) begin
			flag_d = 1'b1;
		end else if (clr_in) begin
			flag_d = 1'b0;
		end
	end

	// Flag register, cleared by reset.
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_out = flag_q;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	// A set always leaves the flag high in the next cycle.
	set_wins_a: assert property (set_in |=> flag_out)
		else $error("flag not set after event");

	// Without a clear strobe a high flag stays high.
	flag_sticky_a: assert property (flag_out && !clr_in |=> flag_out)
		else $error("flag dropped without clear");

endmodule

// >>> sim/bridge_cfg_header_regs_test.sv
// Self-checking bench for the bridge primary-side header registers.
`timescale 1ns/1ps
module bridge_cfg_header_regs_test;
	import bridge_cfg_pkg::*;

	// Revision code handed to the design; the value is arbitrary.
	localparam logic [7:0] REV = 8'h3c;

	// Design ports.
	logic sys_clk_in;
	logic rst_n_in;
	logic cfg_valid_in;
	cfg_req_t cfg_req_in;
	cfg_rsp_t cfg_rsp_out;
	logic serr_msg_sent_in;
	logic system_error_signaled_out;

	// Model state: sticky flag, latency byte and last read answer.
	int sse_m;
	int lat_m;
	logic [31:0] last_rd;
	// Counters, seed and loop scratch.
	int fails;
	int n_checks;
	int cycles;
	int i;
	integer seed;
	logic [31:0] rv;
	logic [31:0] wd;

	bridge_cfg_header_regs #(
		.REVISION_CODE(REV),
		.DW_INDEX_W(6)
	) bridge_cfg_header_regs_inst (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.cfg_valid_in(cfg_valid_in),
		.cfg_req_in(cfg_req_in),
		.cfg_rsp_out(cfg_rsp_out),
		.serr_msg_sent_in(serr_msg_sent_in),
		.system_error_signaled_out(system_error_signaled_out)
	);

	// Free-running 100 MHz clock.
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	// The tests take some 213 cycles, so 3000 only trips on a hang.
	always @(posedge sys_clk_in) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			finish_test();
		end
	end

	// Expected dword contents, written from the register map.
	function automatic logic [31:0] exp_dw(input int idx);
		case (idx)
			1: exp_dw = {(sse_m != 0) ? 16'h4020 : 16'h0020, 16'h0000};
			2: exp_dw = {8'h06, 8'h04, 8'h00, REV};
			3: exp_dw = {8'h00, 8'h01, lat_m[7:0], 8'h00};
			default: exp_dw = 32'h0000_0000;
		endcase
	endfunction

	// Compare a data word; case equality so unknowns never match.
	task automatic chk_word(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	// Compare a single flag.
	task automatic chk_bit(input string what, input logic e, input logic g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask

	// One access, optionally with an event in the same cycle. The answer
	// is checked at the falling edge half a cycle after the taking edge, while ack stands.
	task automatic xfer(input logic wr, input int idx, input logic [3:0] be,
		input logic [31:0] wdat, input logic s);
		@(negedge sys_clk_in);
		chk_bit("ack idle", 1'b0, cfg_rsp_out.ack);
		cfg_valid_in = 1'b1;
		cfg_req_in = '{wr, 6'(idx), be, wdat};
		serr_msg_sent_in = s;
		@(negedge sys_clk_in);
		// A read sees the state from before this edge's updates.
		if (!wr) last_rd = exp_dw(idx);
		// A set event wins over a clear in the same cycle.
		if (s) sse_m = 1;
		else if (wr && idx == 1 && be[3] && wdat[30]) sse_m = 0;
		if (wr && idx == 3 && be[1]) lat_m = int'(wdat[15:8] & 8'hf8);
		chk_bit("ack", 1'b1, cfg_rsp_out.ack);
		chk_word("rdata", last_rd, cfg_rsp_out.rdata);
		chk_bit("flag", sse_m[0], system_error_signaled_out);
		cfg_valid_in = 1'b0;
		serr_msg_sent_in = 1'b0;
	endtask

	// Single place where the run ends.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Main sequence; inputs change only at falling edges.
	initial begin
		seed = 32'hb96f9eb7;
		cycles = 0;
		fails = 0;
		n_checks = 0;
		sse_m = 0;
		lat_m = 0;
		last_rd = 32'h0000_0000;
		rst_n_in = 1'b0;
		cfg_valid_in = 1'b0;
		cfg_req_in = '0;
		serr_msg_sent_in = 1'b0;
		repeat (6) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		// Reset values of every mapped dword.
		for (i = 0; i < 4; i++) xfer(1'b0, i, 4'hf, 32'h0, 1'b0);
		$display("test reset_values done");
		// All ones written everywhere; only latency bits 7:3 may take.
		for (i = 0; i < 4; i++) xfer(1'b1, i, 4'hf, 32'hffff_ffff, 1'b0);
		for (i = 0; i < 4; i++) xfer(1'b0, i, 4'hf, 32'h0, 1'b0);
		$display("test read_only done");
		// Sticky flag: set, kept by zero or masked writes, cleared by one.
		xfer(1'b0, 1, 4'h0, 32'h0, 1'b1);
		xfer(1'b0, 1, 4'hf, 32'h0, 1'b0);
		xfer(1'b1, 1, 4'hf, 32'h0, 1'b0);
		xfer(1'b1, 1, 4'h7, 32'hffff_ffff, 1'b0);
		xfer(1'b1, 1, 4'h8, 32'h4000_0000, 1'b1);
		xfer(1'b1, 1, 4'h8, 32'h4000_0000, 1'b0);
		xfer(1'b0, 1, 4'hf, 32'h0, 1'b0);
		$display("test sticky_flag done");
		// Random traffic, unmapped dwords included, events mixed in.
		for (i = 0; i < 80; i++) begin
			rv = $random(seed);
			wd = $random(seed);
			xfer(rv[0], int'(rv[3] ? rv[9:4] : rv[5:4]), rv[13:10], wd, rv[14] & rv[15]);
		end
		$display("test random_traffic done");
		// Reset in mid-run clears the flag, the latency and the answer.
		xfer(1'b0, 0, 4'h0, 32'h0, 1'b1);
		@(negedge sys_clk_in);
		rst_n_in = 1'b0;
		sse_m = 0;
		lat_m = 0;
		last_rd = 32'h0000_0000;
		@(negedge sys_clk_in);
		chk_bit("flag in reset", 1'b0, system_error_signaled_out);
		chk_word("rdata in reset", 32'h0, cfg_rsp_out.rdata);
		@(negedge sys_clk_in);
		rst_n_in = 1'b1;
		xfer(1'b0, 1, 4'hf, 32'h0, 1'b0);
		xfer(1'b0, 3, 4'hf, 32'h0, 1'b0);
		$display("test second_reset done");
		finish_test();
	end
endmodule
